// file: pkg/mip_pkg.sv
// Package for the extended register portal: offsets, fields, reset values.
// Assumes a 5-bit management register address and 16-bit register data.
package mip_pkg;
  // ==========================================================
  // Portal register offsets on the management register port
  localparam logic [4:0] CTRL_OFFSET = 5'h0d;
  localparam logic [4:0] DATA_OFFSET = 5'h0e;
  // ==========================================================
  // Control portal field positions
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 14;
  localparam int DEV_MSB = 4;
  localparam int DEV_LSB = 0;
  // ==========================================================
  // Widths and reset values
  localparam int DEV_W = 5;
  localparam int REG_W = 16;
  localparam int DATA_W = 16;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  // Implemented extended space held in the local store
  localparam int NUM_DEV = 32;
  localparam int IMPL_REGS = 16;
  // ==========================================================
  // Operation codes of the control portal
  typedef enum logic [1:0] {
    MIP_OP_ADDR = 2'h0,
    MIP_OP_DATA = 2'h1,
    MIP_OP_INC_RW = 2'h2,
    MIP_OP_INC_WR = 2'h3
  } mip_op_t;
  // Management register access, one-cycle strobes
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mip_req_t;
endpackage

// file: hw/mip_store.sv
// Small store of extended registers, indexed by device and register.
// Assumes one access per cycle; read data come out of a register.
`timescale 1ns/1ns
module mip_store #(
  parameter int ADDR_W = 9,
  parameter int DATA_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_we,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic [DATA_W-1:0] o_rdata
);
  // ==========================================================
  // Storage array and registered read
  logic [DATA_W-1:0] mem_ff [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rdata_ff;

  // Write port, no reset on the array
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_ff[i_addr] <= i_wdata;
    end
  end

  // Registered read data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= mem_ff[i_addr];
    end
  end

  assign o_rdata = rdata_ff;
endmodule

// file: hw/mip_portal.sv
// Indirect access portal: control and address/data portal registers.
// Assumes the management frame logic gives one-cycle rd/wr strobes and
// samples o_rdata one cycle after the read strobe.
`timescale 1ns/1ns
module mip_portal #(
  parameter int IMPL_REGS = mip_pkg::IMPL_REGS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire mip_pkg::mip_req_t i_req,
  output logic [15:0] o_rdata,
  output logic [4:0] o_dev,
  output logic [15:0] o_reg_addr
);
  // ==========================================================
  // Portal state
  localparam int LA_W = $clog2(IMPL_REGS);
  // First unimplemented register address of every device
  localparam logic [mip_pkg::REG_W-1:0] IMPL_LIMIT = IMPL_REGS[mip_pkg::REG_W-1:0];
  logic [1:0] op_ff;
  logic [8:0] rsv_ff;
  logic [mip_pkg::DEV_W-1:0] dev_ff;
  logic [mip_pkg::REG_W-1:0] addr_ff;
  logic [15:0] rdata_ff;
  logic rd_data_ff;
  logic rd_impl_ff;
  logic [1:0] nxt_op;
  logic [mip_pkg::REG_W-1:0] nxt_addr;

  // ==========================================================
  // Request decode
  // Only the two portal offsets are decoded; any other management
  // address has no effect and reads back as zero
  wire ctrl_sel = i_req.addr == mip_pkg::CTRL_OFFSET;
  wire data_sel = i_req.addr == mip_pkg::DATA_OFFSET;
  wire ctrl_wr = i_req.wr && ctrl_sel;
  wire data_wr = i_req.wr && data_sel;
  wire data_rd = i_req.rd && data_sel;
  wire is_addr_op = op_ff == mip_pkg::MIP_OP_ADDR;
  wire data_acc_wr = data_wr && !is_addr_op;
  wire data_acc_rd = data_rd && !is_addr_op;
  // Implemented region: low registers of each device
  // Upper addresses still count and wrap, they just never reach the store
  wire impl_hit = addr_ff < IMPL_LIMIT;
  // Post increment selection
  wire inc = (data_acc_wr && op_ff[1]) ||
             (data_acc_rd && op_ff == mip_pkg::MIP_OP_INC_RW);
  wire [15:0] store_rdata;
  wire [mip_pkg::DEV_W+LA_W-1:0] store_addr = {dev_ff, addr_ff[LA_W-1:0]};

  // Store write only for a data code aimed at implemented space
  wire store_we = data_acc_wr && impl_hit;

  // ==========================================================
  // Stored register address
  // Load in address mode, advance after access. The store is read and
  // written with the old address, so the advance never hits this access
  always_comb begin
    nxt_addr = addr_ff;
    if (data_wr && is_addr_op) begin
      nxt_addr = i_req.wdata;
    end else if (inc) begin
      nxt_addr = addr_ff + 16'h0001;
    end
  end

  assign nxt_op = i_req.wdata[mip_pkg::OP_MSB:mip_pkg::OP_LSB];

  // ==========================================================
  // Portal registers
  // Reserved control bits are kept so that a control read returns them
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_ff <= mip_pkg::CTRL_RESET[15:14];
      rsv_ff <= mip_pkg::CTRL_RESET[13:5];
      dev_ff <= mip_pkg::CTRL_RESET[4:0];
      addr_ff <= mip_pkg::DATA_RESET;
    end else begin
      if (ctrl_wr) begin
        op_ff <= nxt_op;
        rsv_ff <= i_req.wdata[13:5];
        dev_ff <= i_req.wdata[mip_pkg::DEV_MSB:mip_pkg::DEV_LSB];
      end
      addr_ff <= nxt_addr;
    end
  end

  // ==========================================================
  // Read path: control and address from the portal registers, data from the store
  // Read data stand for one cycle only, then fall back to zero, so a
  // host must take them in the cycle after its read strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= 16'h0000;
      rd_data_ff <= 1'b0;
      rd_impl_ff <= 1'b0;
    end else begin
      rd_data_ff <= data_acc_rd;
      rd_impl_ff <= impl_hit;
      if (i_req.rd && ctrl_sel) begin
        rdata_ff <= {op_ff, rsv_ff, dev_ff};
      end else if (data_rd && is_addr_op) begin
        rdata_ff <= addr_ff;
      end else begin
        rdata_ff <= 16'h0000;
      end
    end
  end

  // ==========================================================
  // Extended register store, writes only to implemented space
  mip_store #(
    .ADDR_W(mip_pkg::DEV_W + LA_W),
    .DATA_W(mip_pkg::DATA_W)
  ) u_store (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(store_we),
    .i_addr(store_addr),
    .i_wdata(i_req.wdata),
    .o_rdata(store_rdata)
  );

  assign o_rdata = rd_data_ff ? (rd_impl_ff ? store_rdata : 16'h0000) : rdata_ff;
  assign o_dev = dev_ff;
  assign o_reg_addr = addr_ff;

  // ==========================================================
  // Checks
  chk_inc_rw: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (data_rd && op_ff == 2'h2) |=> (addr_ff == $past(addr_ff) + 16'h0001))
    else $error("address did not advance on read in mode 10");
  chk_no_inc_rd: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (data_rd && op_ff == 2'h3 && !i_req.wr) |=> $stable(addr_ff))
    else $error("address moved on read in mode 11");
  chk_inc_wr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (data_wr && op_ff[1]) |=> (addr_ff == $past(addr_ff) + 16'h0001))
    else $error("address did not advance on write");
  chk_no_inc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (data_sel && op_ff == 2'h1) |=> $stable(addr_ff))
    else $error("address moved in mode 01");
  chk_addr_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (data_wr && op_ff == 2'h0) |=> (addr_ff == $past(i_req.wdata)))
    else $error("address not loaded in mode 00");
  chk_addr_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (data_rd && !i_req.wr && op_ff == 2'h0) |=> (o_rdata == $past(addr_ff)))
    else $error("address readback wrong");
  chk_dev_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ctrl_wr |=> (o_dev == $past(i_req.wdata[4:0])))
    else $error("device field not loaded");
  chk_unimpl_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (data_acc_rd && !impl_hit) |=> (o_rdata == 16'h0000))
    else $error("unimplemented register read not zero");
  chk_data_wrrd: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (data_wr && op_ff == 2'h1 && impl_hit) ##1 (data_rd && op_ff == 2'h1 && !i_req.wr)
      |=> (o_rdata == $past(i_req.wdata, 2)))
    else $error("data written not read back");
  chk_reset_zero: assert property (@(posedge i_clk)
    $rose(i_rst_n) |-> (op_ff == 2'h0 && dev_ff == 5'h00 && addr_ff == 16'h0000))
    else $error("portal not zero after reset");

  // ==========================================================
  // Control register, stored address and read data checks
  // Operation code takes bits 15:14 of a control write
  chk_op_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ctrl_wr |=> (op_ff == $past(i_req.wdata[15:14])))
    else $error("operation code not loaded");

  // Operation code holds between control writes
  chk_op_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !ctrl_wr |=> $stable(op_ff))
    else $error("operation code moved without control write");

  // Device field holds between control writes
  chk_dev_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !ctrl_wr |=> $stable(o_dev))
    else $error("device field moved without control write");

  // Control read returns code and device of the edge it was taken on
  chk_ctrl_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req.rd && !i_req.wr && ctrl_sel) |=>
      (o_rdata[4:0] == $past(o_dev) && o_rdata[15:14] == $past(op_ff)))
    else $error("control readback wrong");

  // Stored address only moves through the data portal
  chk_addr_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !data_sel |=> $stable(o_reg_addr))
    else $error("address moved without data portal access");

  // Reading the address back in mode 00 leaves it in place
  chk_addr_rd_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (data_rd && !i_req.wr && op_ff == 2'h0) |=> $stable(o_reg_addr))
    else $error("address moved on readback in mode 00");

  // Advance past the top address wraps to zero
  chk_addr_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (data_wr && op_ff[1] && addr_ff == 16'hffff) |=> (o_reg_addr == 16'h0000))
    else $error("address did not wrap");

  // Writes to unimplemented space still advance the address
  chk_unimpl_inc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (data_wr && op_ff[1] && !impl_hit) |=> (o_reg_addr == $past(addr_ff) + 16'h0001))
    else $error("address did not advance on unimplemented write");

  // Read data stand for one cycle and fall back to zero
  chk_rd_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_req.rd |=> (o_rdata == 16'h0000))
    else $error("read data stood without a read");
endmodule

// file: tb/mip_host_model.sv
// Host model: management controller making portal accesses.
// Assumes one-cycle strobes and read data one cycle after the read.
`timescale 1ns/1ns
module mip_host_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output mip_pkg::mip_req_t o_req
);
  // ====
  // Bus cycles
  initial o_req = '0;
  // One write strobe, then idle
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk) o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk) o_req <= '0;
    #1;
  endtask
  // One read strobe, data taken in the cycle after
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_clk) o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge i_clk) o_req <= '0;
    #1 d = i_rdata;
  endtask
  // Write then read in back-to-back cycles, data taken after the read
  task automatic wr_rd(input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge i_clk) o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk) o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge i_clk) o_req <= '0;
    #1 q = i_rdata;
  endtask
  // Device select, address load, then data code
  task automatic point(input logic [15:0] c, input logic [15:0] ra);
    wr(mip_pkg::CTRL_OFFSET, c & 16'h001f);
    wr(mip_pkg::DATA_OFFSET, ra);
    wr(mip_pkg::CTRL_OFFSET, c);
  endtask
endmodule

// file: tb/mip_portal_tb_top.sv
// Testbench for the extended register portal.
// Assumes the host model drives all requests.
`timescale 1ns/1ns
module mip_portal_tb_top;
  localparam logic [4:0] C = mip_pkg::CTRL_OFFSET;
  localparam logic [4:0] D = mip_pkg::DATA_OFFSET;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  mip_pkg::mip_req_t req;
  logic [15:0] rdata;
  logic [15:0] reg_addr;
  logic [15:0] v;
  logic [4:0] dev;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // ====
  // Design and host
  mip_portal u_mip_portal (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req),
    .o_rdata(rdata), .o_dev(dev), .o_reg_addr(reg_addr));
  mip_host_model u_mip_host_model (.i_clk(i_clk), .i_rdata(rdata), .o_req(req));
  initial forever #4 i_clk = ~i_clk;
  // Compare and count
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic t_reset_addr();
    u_mip_host_model.rd(C, v);
    check("ctrl_rst", 16'h0000, v);
    u_mip_host_model.rd(D, v);
    check("data_rst", 16'h0000, v);
    u_mip_host_model.wr(C, 16'h0002);
    check("dev", 16'h0002, {11'h000, dev});
    u_mip_host_model.wr(D, 16'h0003);
    u_mip_host_model.rd(D, v);
    check("addr_rd", 16'h0003, v);
  endtask
  task automatic t_modes();
    u_mip_host_model.point(16'h4002, 16'h0003);
    u_mip_host_model.wr(D, 16'h1234);
    u_mip_host_model.rd(D, v);
    check("noinc", 16'h1234, v);
    check("noinc_a", 16'h0003, reg_addr);
    u_mip_host_model.wr_rd(D, 16'h4321, v);
    check("b2b", 16'h4321, v);
    u_mip_host_model.point(16'h8002, 16'h0004);
    u_mip_host_model.wr(D, 16'h00a1);
    u_mip_host_model.wr(D, 16'h00b2);
    check("inc_w", 16'h0006, reg_addr);
    u_mip_host_model.point(16'h8002, 16'h0004);
    u_mip_host_model.rd(D, v);
    check("run0", 16'h00a1, v);
    u_mip_host_model.rd(D, v);
    check("run1", 16'h00b2, v);
    u_mip_host_model.point(16'hc002, 16'h0005);
    u_mip_host_model.rd(D, v);
    u_mip_host_model.rd(D, v);
    check("wo_rd", 16'h0005, reg_addr);
    u_mip_host_model.wr(D, 16'h00c3);
    check("wo_wr", 16'h0006, reg_addr);
  endtask
  task automatic t_edges();
    u_mip_host_model.point(16'h401f, 16'h0005);
    u_mip_host_model.rd(C, v);
    check("ctrl_rd", 16'h401f, v);
    u_mip_host_model.wr(D, 16'h5a5a);
    u_mip_host_model.point(16'h4002, 16'h0005);
    u_mip_host_model.rd(D, v);
    check("dev_sep", 16'h00c3, v);
    u_mip_host_model.point(16'h8002, 16'h0010);
    u_mip_host_model.rd(D, v);
    check("unimpl", 16'h0000, v);
    check("unimpl_a", 16'h0011, reg_addr);
    u_mip_host_model.point(16'hc002, 16'hffff);
    u_mip_host_model.wr(D, 16'h7777);
    check("wrap", 16'h0000, reg_addr);
    u_mip_host_model.wr(C, 16'h3fe2);
    u_mip_host_model.rd(C, v);
    check("ctrl_rsv", 16'h3fe2, v);
    u_mip_host_model.rd(5'h00, v);
    check("unmapped", 16'h0000, v);
  endtask
  // Reset in mid-run clears both portals
  task automatic t_rerun_reset();
    @(posedge i_clk) i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    check("rst_dev", 16'h0000, {11'h000, dev});
    check("rst_addr", 16'h0000, reg_addr);
    u_mip_host_model.rd(C, v);
    check("rst_ctrl", 16'h0000, v);
    u_mip_host_model.rd(D, v);
    check("rst_data", 16'h0000, v);
  endtask
  // Hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset_addr();
    t_modes();
    t_edges();
    t_rerun_reset();
    print_verdict();
  end
endmodule
